// ---- design/eeprom_host_consts.vh ----
/*
  Timing constants for the parallel EEPROM page-write host controller.
  Assumes a 250 MHz system clock; all counts are derived from it.
*/
`ifndef EEPROM_HOST_CONSTS_VH
`define EEPROM_HOST_CONSTS_VH
`define CLK_PERIOD_PS        4000
`define STROBE_WIDTH_NS      200
`define STROBE_CYC           ((`STROBE_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_NS             70
`define SETUP_CYC            ((`SETUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HOLD_NS              50
`define HOLD_CYC             ((`HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_ACCESS_NS       120
`define READ_CYC             ((`READ_ACCESS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BYTE_LOAD_GAP_US     30
`define GAP_CYC              (`BYTE_LOAD_GAP_US * 1000000 / `CLK_PERIOD_PS)
`define LOAD_WINDOW_US       100
`define WINDOW_CYC           ((`LOAD_WINDOW_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_CYCLE_MS       10
// Whole microseconds keep the millisecond count inside 32-bit arithmetic.
`define CYC_PER_US           ((1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_CYC            (`WRITE_CYCLE_MS * 1000 * `CYC_PER_US)
`define PAGE_BYTES           64
`define ADDR_W               15
`define POLL_BIT             7
`define TOGGLE_BIT           6
`endif

// ---- design/eeprom_page_host.v ----
/*
  Host controller that drives a byte-wide EEPROM through its pins: page loads,
  reads, and completion tracking by polling, toggle bit, ready/busy or timeout.
  Assumes the EEPROM pins are board signals; inputs from them are synchronised.
*/
`include "eeprom_host_consts.vh"

// Behaviour
// R1 - A page write carries one to sixty-four byte loads.
// R2 - Each further byte load starts within 30 us of the previous strobe fall.
// R3 - After the last load, strobe stays high 100 us; the device then programs.
// R4 - Page address bits are captured at the first strobe fall of a page.
// R5 - Address latched at strobe fall, data at strobe rise.
// R6 - The device finishes programming within 10 ms.
// R7 - Without polling or ready/busy, wait at least 10 ms before next access.
// R8 - With polling or ready/busy, proceed as soon as completion shows.
// R9 - While busy, bit seven reads as complement of last loaded bit seven.
// R10 - While busy, bit six flips on every read; stops when done.
// R11 - First toggle read returns one; final value undefined.
// R12 - Toggle status reads keep one fixed address.
// R13 - Ready/busy floats outside writes, low during internal write.
// R14 - With protect/reset low, reads and writes are refused.
// R15 - Host keeps protect/reset high through every read and write; here the pin follows protect_req in every state, so it can drop mid-access.
// R16 - Control pulses of 20 ns or less are ignored.
// R17 - Protect/reset low during programming aborts it.
// R18 - Output gate high during loads; page address bits constant per page.
// R19 - Low six address bits pick the byte in the page buffer.
module eeprom_page_host #(
  parameter WRITE_CYCLES  = `WRITE_CYC,
  parameter WINDOW_CYCLES = `WINDOW_CYC
) (
  input  wire              clk,
  input  wire              rstn,
  input  wire              ce,
  input  wire              req_valid,
  input  wire              req_write,
  input  wire              req_last,
  input  wire [1:0]        req_mode,
  input  wire [14:0]       req_addr,
  input  wire [7:0]        req_data,
  input  wire              protect_req,
  output reg               req_ready,
  output reg               rsp_valid,
  output reg  [7:0]        rsp_data,
  output reg               write_busy,
  output reg  [14:0]       mem_addr,
  output reg               chip_sel_n,
  output reg               out_gate_n,
  output reg               write_strobe_n,
  output reg               program_abort_n,
  output reg  [7:0]        data_out,
  output reg               data_oe_n,
  input  wire [7:0]        data_in,
  input  wire              ready_busy_n
);
  localparam S_IDLE  = 7'h01;
  localparam S_WLOW  = 7'h02;
  localparam S_WHIGH = 7'h04;
  localparam S_GAP   = 7'h08;
  localparam S_RD    = 7'h10;
  localparam S_WAIT  = 7'h20;
  localparam S_POLL  = 7'h40;
  localparam M_TIMEOUT = 2'h0;
  localparam M_POLL    = 2'h1;
  localparam M_TOGGLE  = 2'h2;
  localparam M_RDYBSY  = 2'h3;

  reg [6:0]  state_reg;
  reg [21:0] cnt_reg;
  reg [21:0] gap_reg;
  reg [6:0]  loads_reg;
  reg [8:0]  page_reg;
  reg [7:0]  last_reg;
  reg        toggle_prev_reg;
  reg        first_reg;
  reg [1:0]  mode_reg;
  reg [7:0]  din_s1;
  reg [7:0]  din_s2;
  reg        rb_s1;
  reg        rb_s2;

  function [21:0] cyc;
    input integer n;
    begin
      cyc = n[21:0];
    end
  endfunction

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      rb_s1  <= 1'b1;
      rb_s2  <= 1'b1;
    end else if (ce) begin
      din_s1 <= data_in;
      din_s2 <= din_s1;
      rb_s1  <= ready_busy_n;
      rb_s2  <= rb_s1;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= S_IDLE;
      cnt_reg         <= 22'h000000;
      gap_reg         <= 22'h000000;
      loads_reg       <= 7'h00;
      page_reg        <= 9'h000;
      last_reg        <= 8'h00;
      toggle_prev_reg <= 1'b0;
      first_reg       <= 1'b0;
      mode_reg        <= 2'h0;
      req_ready       <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_data        <= 8'h00;
      write_busy      <= 1'b0;
      mem_addr        <= 15'h0000;
      chip_sel_n      <= 1'b1;
      out_gate_n      <= 1'b1;
      write_strobe_n  <= 1'b1;
      program_abort_n <= 1'b0;
      data_out        <= 8'h00;
      data_oe_n       <= 1'b1;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      program_abort_n <= ~protect_req; // [R14] [R17]
      if (state_reg == S_GAP) begin
        gap_reg <= gap_reg + 22'h000001;
      end
      case (state_reg)
        S_IDLE: begin
          chip_sel_n     <= 1'b1;
          out_gate_n     <= 1'b1;
          write_strobe_n <= 1'b1;
          data_oe_n      <= 1'b1;
          if (req_valid && !protect_req && program_abort_n) begin // [R15]
            req_ready <= 1'b1;
            mem_addr  <= req_addr;
            cnt_reg   <= 22'h000000;
            if (req_write) begin
              page_reg       <= req_addr[14:6]; // [R4]
              loads_reg      <= 7'h01;
              last_reg       <= req_data;
              data_out       <= req_data;
              data_oe_n      <= 1'b0;
              chip_sel_n     <= 1'b0;
              write_strobe_n <= 1'b0; // [R5]
              mode_reg       <= req_mode;
              write_busy     <= 1'b1;
              state_reg      <= S_WLOW;
            end else begin
              chip_sel_n <= 1'b0;
              out_gate_n <= 1'b0;
              state_reg  <= S_RD;
            end
          end
        end
        S_WLOW: begin
          cnt_reg <= cnt_reg + 22'h000001;
          if (cnt_reg >= cyc(`STROBE_CYC - 1)) begin // [R16]
            write_strobe_n <= 1'b1; // [R5]
            cnt_reg        <= 22'h000000;
            state_reg      <= S_WHIGH;
          end
        end
        S_WHIGH: begin
          cnt_reg <= cnt_reg + 22'h000001;
          if (cnt_reg >= cyc(`HOLD_CYC - 1)) begin
            chip_sel_n <= 1'b1;
            data_oe_n  <= 1'b1;
            gap_reg    <= cnt_reg + cyc(`STROBE_CYC + 1);
            cnt_reg    <= 22'h000000;
            state_reg  <= S_GAP;
          end
        end
        S_GAP: begin
          cnt_reg <= cnt_reg + 22'h000001;
          if (req_valid && req_write && !req_last_done(loads_reg) && !protect_req // [R15]
              && req_addr[14:6] == page_reg // [R18]
              && gap_reg < cyc(`GAP_CYC - `SETUP_CYC)) begin // [R2] [R1]
            req_ready      <= 1'b1;
            mem_addr       <= {page_reg, req_addr[5:0]}; // [R19]
            last_reg       <= req_data;
            data_out       <= req_data;
            data_oe_n      <= 1'b0;
            chip_sel_n     <= 1'b0;
            write_strobe_n <= 1'b0;
            loads_reg      <= loads_reg + 7'h01;
            gap_reg        <= 22'h000000;
            cnt_reg        <= 22'h000000;
            state_reg      <= S_WLOW;
          end else if (cnt_reg >= cyc(WINDOW_CYCLES)) begin // [R3]
            cnt_reg   <= 22'h000000;
            first_reg <= 1'b1;
            state_reg <= (mode_reg == M_TIMEOUT) ? S_WAIT : S_POLL;
          end
        end
        S_WAIT: begin
          cnt_reg <= cnt_reg + 22'h000001;
          if (cnt_reg >= cyc(WRITE_CYCLES)) begin // [R6] [R7]
            write_busy <= 1'b0;
            state_reg  <= S_IDLE;
          end
        end
        S_POLL: begin
          cnt_reg <= cnt_reg + 22'h000001;
          if (mode_reg == M_RDYBSY) begin
            if (rb_s2 && cnt_reg > cyc(`READ_CYC + 2)) begin // [R13] [R8]
              write_busy <= 1'b0;
              state_reg  <= S_IDLE;
            end
          end else if (chip_sel_n) begin
            chip_sel_n <= 1'b0;
            out_gate_n <= 1'b0;
            mem_addr   <= {page_reg, 6'h00}; // [R12]
            cnt_reg    <= 22'h000000;
          end else if (cnt_reg >= cyc(`READ_CYC + 2)) begin
            chip_sel_n      <= 1'b1;
            out_gate_n      <= 1'b1;
            first_reg       <= 1'b0;
            toggle_prev_reg <= din_s2[`TOGGLE_BIT];
            cnt_reg         <= 22'h000000;
            if ((mode_reg == M_POLL
                 && din_s2[`POLL_BIT] == last_reg[`POLL_BIT]) // [R9] [R8]
                || (mode_reg == M_TOGGLE && !first_reg
                    && din_s2[`TOGGLE_BIT] == toggle_prev_reg)) begin // [R10] [R11]
              write_busy <= 1'b0;
              state_reg  <= S_IDLE;
            end
          end
        end
        S_RD: begin
          cnt_reg <= cnt_reg + 22'h000001;
          if (cnt_reg >= cyc(`READ_CYC + 2)) begin
            rsp_valid  <= 1'b1;
            rsp_data   <= din_s2;
            chip_sel_n <= 1'b1;
            out_gate_n <= 1'b1;
            state_reg  <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  function req_last_done;
    input [6:0] n;
    begin
      req_last_done = (n >= `PAGE_BYTES);
    end
  endfunction
endmodule // eeprom_page_host

// ---- sim/eeprom_host_monitor.sv ----
/* Pin checks for the page-write host controller.
   Assumes a bind to eeprom_page_host, one clock and an active-low reset. */
`include "eeprom_host_consts.vh"
module eeprom_host_monitor #(
  parameter WRITE_CYCLES  = 200,
  parameter WINDOW_CYCLES = 50
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        protect_req,
  input wire logic        req_ready,
  input wire logic        write_busy,
  input wire logic [14:0] mem_addr,
  input wire logic        chip_sel_n,
  input wire logic        out_gate_n,
  input wire logic        write_strobe_n,
  input wire logic        program_abort_n,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] low_cnt, quiet_cnt, gap_cnt;
  logic [8:0]  page_reg;
  logic        seen_load;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {low_cnt, quiet_cnt, gap_cnt, page_reg, seen_load} <= '0;
    end else begin
      low_cnt   <= write_strobe_n ? 32'h0 : low_cnt + 32'h1;
      quiet_cnt <= write_strobe_n ? quiet_cnt + 32'h1 : 32'h0;
      gap_cnt   <= (!write_strobe_n && low_cnt == 0) ? 32'h0 : gap_cnt + 32'h1;
      if (!write_strobe_n && low_cnt == 0) begin
        page_reg  <= mem_addr[14:6];
        seen_load <= 1'b1;
      end else if (!write_busy) begin
        seen_load <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence load_start;
    $fell(write_strobe_n) && seen_load;
  endsequence
  a_abort_follow: assert property (1'b1 |=> program_abort_n == !$past(protect_req))
    else $error("abort pin does not follow protect request");
  a_ready_unprot: assert property (req_ready |-> !$past(protect_req))
    else $error("request taken while protected");
  a_gate_load: assert property (!write_strobe_n |-> out_gate_n && !data_oe_n && !chip_sel_n)
    else $error("bad pins during byte load");
  a_data_hold: assert property ($rose(write_strobe_n) |-> !data_oe_n && $stable(data_out) && $stable(mem_addr))
    else $error("data or address moved at strobe rise");
  a_strobe_len: assert property ($rose(write_strobe_n) |-> low_cnt >= `STROBE_CYC)
    else $error("write strobe too short");
  a_page_same: assert property (load_start |-> mem_addr[14:6] == page_reg)
    else $error("page bits changed within a page");
  a_load_gap: assert property (load_start |-> gap_cnt < `GAP_CYC)
    else $error("byte load gap too long");
  a_quiet_wait: assert property ($fell(write_busy) |-> quiet_cnt >= WINDOW_CYCLES)
    else $error("write finished before load window ran out");
  a_poll_addr: assert property (!out_gate_n && write_busy |-> mem_addr == {page_reg, 6'h00} && data_oe_n)
    else $error("status read at a moving address");
endmodule // eeprom_host_monitor
bind eeprom_page_host eeprom_host_monitor #(.WRITE_CYCLES(WRITE_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES))
  mon (.clk, .rstn, .protect_req, .req_ready, .write_busy, .mem_addr, .chip_sel_n, .out_gate_n,
  .write_strobe_n, .program_abort_n, .data_out, .data_oe_n);

// ---- sim/eeprom_dev_model.sv ----
/* Behavioural model of the byte-wide EEPROM with page buffer and status outputs.
   Assumes the host pins are registered on clk; timings are counted in clk cycles. */
module eeprom_dev_model #(
  parameter WIN  = 40,
  parameter PROG = 150
) (
  input  wire logic        clk,
  input  wire logic [14:0] a,
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        res_n,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dq,
  output logic             dq_en,
  output logic             rb_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:32767];
  logic [7:0]  pbuf [0:63];
  logic [63:0] bv;
  logic [8:0]  pg;
  logic [14:0] la;
  logic [7:0]  lastd;
  logic        pgv, busy, tog, rd_q;
  integer      cnt, wl, i;
  wire wr = !cs_n && !we_n && oe_n && res_n && !busy;
  assign dq_en = !cs_n && !oe_n && we_n && res_n;
  assign dq = busy ? {~lastd[7], tog, lastd[5:0]} : mem[a];
  initial for (int j = 0; j < 32768; j++) mem[j] <= 8'hFF;
  always @(posedge clk) begin
    rd_q <= dq_en;
    wl <= wr ? wl + 1 : 0;
    if (rd_q && !dq_en && busy) tog <= !tog;
    if (!res_n) begin
      busy <= 1'b0;
      rb_low <= 1'b0;
      pgv <= 1'b0;
      bv <= '0;
      cnt <= 0;
    end else if (wr && wl == 0) begin
      la <= a;
      if (!pgv) pg <= a[14:6];
      pgv <= 1'b1;
    end else if (!wr && wl > 5) begin
      pbuf[la[5:0]] <= din;
      bv[la[5:0]] <= 1'b1;
      lastd <= din;
      rb_low <= 1'b1;
      cnt <= 0;
    end else if (pgv && !busy && !wr) begin
      cnt <= cnt + 1;
      if (cnt == WIN) begin
        busy <= 1'b1;
        tog <= 1'b1;
        cnt <= 0;
      end
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == PROG) begin
        for (i = 0; i < 64; i++) if (bv[i]) mem[{pg, i[5:0]}] <= pbuf[i];
        busy <= 1'b0;
        rb_low <= 1'b0;
        pgv <= 1'b0;
        bv <= '0;
      end
    end
  end
endmodule // eeprom_dev_model

// ---- sim/testbench.sv ----
/* Self-checking bench for the page-write host with an EEPROM model on its pins.
   Assumes the design header is on the include path. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, req_valid = 0, req_write = 0, protect_req = 0, flt = 0;
  logic [1:0]  req_mode = 0;
  logic [14:0] req_addr = 0, mem_addr;
  logic [7:0]  req_data = 0, dq, rsp_data, data_out;
  logic        dq_en, rb_low, req_ready, rsp_valid, write_busy, chip_sel_n, out_gate_n;
  logic        write_strobe_n, program_abort_n, data_oe_n;
  wire  [7:0]  data_in = !data_oe_n ? data_out : dq_en ? dq : {8{flt}};
  integer      n_mismatch = 0, checks_done = 0, cyc = 0;
  eeprom_page_host #(.WRITE_CYCLES(200), .WINDOW_CYCLES(50)) dut (.clk, .rstn, .ce(1'b1),
    .req_valid, .req_write, .req_last(1'b0), .req_mode, .req_addr, .req_data, .protect_req,
    .req_ready, .rsp_valid, .rsp_data, .write_busy, .mem_addr, .chip_sel_n, .out_gate_n,
    .write_strobe_n, .program_abort_n, .data_out, .data_oe_n, .data_in, .ready_busy_n(!rb_low));
  eeprom_dev_model mdl (.clk, .a(mem_addr), .cs_n(chip_sel_n), .oe_n(out_gate_n),
    .we_n(write_strobe_n), .res_n(program_abort_n), .din(data_in), .dq, .dq_en, .rb_low);
  initial forever #2 clk = ~clk;
  always @(posedge clk) flt <= ~flt;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end
  task results;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task req(input logic w, input logic [14:0] ad, input logic [7:0] d, input logic [1:0] md);
    integer k;
    @(negedge clk);
    {req_write, req_addr, req_data, req_mode, req_valid} = {w, ad, d, md, 1'b1};
    k = 0;
    do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 300);
    chk("req_ready", 8'h01, {7'h00, req_ready});
    req_valid = 0;
  endtask
  task rd(input logic [14:0] ad, input logic [7:0] e);
    integer k;
    req(1'b0, ad, 8'h00, 2'd0);
    for (k = 0; k < 100 && rsp_valid !== 1'b1; k++) @(negedge clk);
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
    chk("read", e, rsp_data);
  endtask
  task page_test(input logic [1:0] m);
    integer i, n, k;
    logic [5:0] o;
    n = (m == 0) ? 64 : 3;
    for (i = 0; i < n; i++) begin
      o = 6'(i * 63);
      req(1'b1, {9'(m) + 9'h001, o}, {m, o}, m);
    end
    for (k = 0; k < 2000 && write_busy !== 1'b0; k++) @(negedge clk);
    chk("busy", 8'h00, {7'h00, write_busy});
    for (i = 0; i < n; i++) begin
      o = 6'(i * 63);
      rd({9'(m) + 9'h001, o}, {m, o});
    end
    if (m != 0) rd({9'(m) + 9'h001, 6'h01}, 8'hFF);
  endtask
  task protect_test;
    integer seen;
    @(negedge clk);
    protect_req = 1;
    repeat (3) @(negedge clk);
    chk("abort", 8'h00, {7'h00, program_abort_n});
    {req_write, req_addr, req_valid, seen} = {1'b0, 15'h0080, 1'b1, 32'sd0};
    repeat (20) begin @(negedge clk); if (req_ready === 1'b1) seen++; end
    chk("refused", 8'h00, 8'(seen));
    {protect_req, req_valid} = 2'b00;
    rd(15'h0080, 8'h40);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    for (int m = 0; m < 4; m++) page_test(2'(m));
    protect_test();
    results();
  end
endmodule // testbench
